/* hw/hts_pkg.sv */
/*
  constants, command codes and carrier types of the humidity and
  temperature sensor serial command port.
  assumes a single 20 MHz system clock and a synchronous active-low reset.
*/
package hts_pkg;

  // system clock
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CLK_PER_MS = CLK_HZ / 1000;

  // times in milliseconds, as specified
  localparam int unsigned SETTLE_MS = 20; // power-up and soft-reset settling, longest
  localparam int unsigned INIT_MS = 10; // initialization processing
  localparam int unsigned CONV_MS = 80; // conversion, done within the host wait

  // times in clock cycles (longest times round down)
  localparam int unsigned SETTLE_CYC = SETTLE_MS * CLK_PER_MS;
  localparam int unsigned INIT_CYC = INIT_MS * CLK_PER_MS;
  localparam int unsigned CONV_CYC = CONV_MS * CLK_PER_MS;

  // bus address and direction
  localparam logic [6:0] TARGET_ADDR = 7'h38;
  localparam logic DIR_READ = 1'b1;

  // command bytes and their parameters
  localparam logic [7:0] CMD_INIT = 8'hBE;
  localparam logic [7:0] CMD_MEAS = 8'hAC;
  localparam logic [7:0] CMD_STATUS = 8'h71;
  localparam logic [7:0] CMD_SOFT_RESET = 8'hBA;
  localparam logic [7:0] INIT_PARAM0 = 8'h08;
  localparam logic [7:0] INIT_PARAM1 = 8'h00;
  localparam logic [7:0] MEAS_PARAM0 = 8'h33;
  localparam logic [7:0] MEAS_PARAM1 = 8'h00;

  // status byte fields
  localparam int unsigned STAT_BUSY_BIT = 7;
  localparam int unsigned STAT_CAL_BIT = 3;

  // crc-8, x^8+x^5+x^4+1
  localparam logic [7:0] CRC_POLY = 8'h31;
  localparam logic [7:0] CRC_INIT = 8'hFF;

  // read sequence: status, six data bytes incl. crc, then filler
  localparam logic [2:0] RD_LAST = 3'h6;
  localparam logic [7:0] RD_FILL = 8'hFF;

  // raw conversion result
  typedef struct packed {
    logic [19:0] raw_humidity_value;
    logic [19:0] raw_temperature_value;
  } result_t;

endpackage : hts_pkg

/* hw/hts_cmd_port.sv */
/*
  serial command and readout port of the humidity and temperature sensor:
  bus target at a fixed address, command decoder, busy/calibration
  sequencing and the result readout with crc.
  assumes scl/sda arrive asynchronously from open-drain pins and that the
  sensing core delivers a stable raw result on mclk when asked.
*/
`timescale 1ns/1ns

// Functional notes
// - after power-up, become idle within 20 ms; never pull the clock low.
// - first byte holds the fixed address 0x38 and a direction bit.
// - direction bit one reads, zero writes.
// - after the eighth falling clock edge, pull data low to acknowledge.
// - 0xBE initializes, 0xAC triggers a measurement; host waits for completion.
// - initialization takes parameters 0x08 then 0x00; host waits 10 ms.
// - measurement takes parameters 0x33 then 0x00, which start a conversion.
// - command 0x71 makes the next read return the status byte.
// - status bit 7 is one while measuring, zero when done.
// - status bit 3 is one when calibrated; other bits read zero.
// - host waits 80 ms, polls busy, then reads six bytes.
// - a seventh byte carries crc-8 x^8+x^5+x^4+1 over the six bytes.
// - command 0xBA reinitializes to defaults within 20 ms.
// - host data is sampled on rising clock, changes only after falling clock.
module hts_cmd_port #(
  parameter int unsigned SETTLE_CYC = hts_pkg::SETTLE_CYC,
  parameter int unsigned INIT_CYC = hts_pkg::INIT_CYC,
  parameter int unsigned CONV_CYC = hts_pkg::CONV_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // serial clock pin
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  // serial data pin
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // sensing core
  output logic conv_start,
  input wire hts_pkg::result_t sensor_raw
);

  typedef enum {ST_IDLE, ST_RECV, ST_ACK, ST_SEND, ST_HACK} bus_state_t;
  typedef enum {PH_SETTLE, PH_READY, PH_INIT, PH_CONV} phase_t;

  // crc-8 over the status byte and the five result bytes
  function automatic logic [7:0] crc8(input logic [47:0] data);
    logic [7:0] c;
    c = hts_pkg::CRC_INIT;
    for (int i = 47; i >= 0; i--) begin
      if (c[7] ^ data[i]) begin
        c = {c[6:0], 1'b0} ^ hts_pkg::CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction : crc8

  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  bus_state_t state;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic [7:0] txsh;
  logic first_byte;
  logic dir_rd;
  logic host_ack;
  logic drive_low;
  logic [2:0] rd_idx;
  logic [1:0] wr_idx;
  logic byte_stb;
  logic [7:0] cmd;
  logic [7:0] param0;
  logic soft_rst;
  logic start_init;
  logic start_conv;
  phase_t phase;
  logic [31:0] timer;
  logic calibrated;
  hts_pkg::result_t result;
  logic [7:0] status;
  logic [47:0] rd_data;
  logic [7:0] next_tx;

  // index of the crc byte in the read sequence
  localparam logic [2:0] RD_LAST_IDX = hts_pkg::RD_LAST;

  // pin synchronisers; bit 0 is read only by bit 1
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
    end else begin
      scl_sync <= {scl_sync[1:0], scl_in};
      sda_sync <= {sda_sync[1:0], sda_in};
    end
  end

  // bus edges and framing conditions
  assign scl_rise = scl_sync[1] & ~scl_sync[2];
  assign scl_fall = ~scl_sync[1] & scl_sync[2];
  assign start_det = scl_sync[1] & scl_sync[2] & ~sda_sync[1] & sda_sync[2];
  assign stop_det = scl_sync[1] & scl_sync[2] & sda_sync[1] & ~sda_sync[2];

  // open-drain drive: data only ever pulled low, clock never held
  assign sda_out = 1'b0;
  assign sda_oe = drive_low;
  assign scl_out = 1'b0;
  assign scl_oe = 1'b0;

  // readout bytes: status, humidity msb first, shared nibble, temperature
  assign status = {phase == PH_CONV, 3'h0, calibrated, 3'h0};
  assign rd_data = {status, result.raw_humidity_value, result.raw_temperature_value};

  // byte to send for the current read index
  always_comb begin
    if (rd_idx < RD_LAST_IDX) begin
      next_tx = rd_data[47 - 8 * rd_idx -: 8];
    end else if (rd_idx == RD_LAST_IDX) begin
      next_tx = crc8(rd_data);
    end else begin
      next_tx = hts_pkg::RD_FILL;
    end
  end

  // bus target state machine
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      txsh <= 8'h00;
      first_byte <= 1'b0;
      dir_rd <= 1'b0;
      host_ack <= 1'b0;
      drive_low <= 1'b0;
      rd_idx <= 3'h0;
      wr_idx <= 2'h0;
      byte_stb <= 1'b0;
    end else begin
      byte_stb <= 1'b0;
      if (start_det) begin
        state <= ST_RECV;
        bitcnt <= 4'h0;
        first_byte <= 1'b1;
        drive_low <= 1'b0;
        rd_idx <= 3'h0;
        wr_idx <= 2'h0;
      end else if (stop_det) begin
        state <= ST_IDLE;
        drive_low <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            drive_low <= 1'b0;
          end
          ST_RECV: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_sync[1]};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == 4'h8) begin
              if (!first_byte) begin
                state <= ST_ACK;
                drive_low <= 1'b1;
                byte_stb <= 1'b1;
              end else if (shreg[7:1] == hts_pkg::TARGET_ADDR && phase != PH_SETTLE) begin
                state <= ST_ACK;
                drive_low <= 1'b1;
                dir_rd <= (shreg[0] == hts_pkg::DIR_READ);
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              bitcnt <= 4'h0;
              if (!first_byte && wr_idx != 2'h3) begin
                wr_idx <= wr_idx + 2'h1;
              end
              first_byte <= 1'b0;
              if (dir_rd) begin
                state <= ST_SEND;
                txsh <= next_tx;
                drive_low <= ~next_tx[7];
                rd_idx <= rd_idx + 3'h1;
              end else begin
                state <= ST_RECV;
                drive_low <= 1'b0;
              end
            end
          end
          ST_SEND: begin
            if (scl_fall) begin
              bitcnt <= bitcnt + 4'h1;
              if (bitcnt == 4'h7) begin
                state <= ST_HACK;
                drive_low <= 1'b0;
              end else begin
                txsh <= {txsh[6:0], 1'b0};
                drive_low <= ~txsh[6];
              end
            end
          end
          ST_HACK: begin
            if (scl_rise) begin
              host_ack <= ~sda_sync[1];
            end else if (scl_fall) begin
              bitcnt <= 4'h0;
              if (host_ack) begin
                state <= ST_SEND;
                txsh <= next_tx;
                drive_low <= ~next_tx[7];
                if (rd_idx != 3'h7) begin
                  rd_idx <= rd_idx + 3'h1;
                end
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
            drive_low <= 1'b0;
          end
        endcase
      end
    end
  end

  // command decoder: command byte, then two parameter bytes
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cmd <= 8'h00;
      param0 <= 8'h00;
      soft_rst <= 1'b0;
      start_init <= 1'b0;
      start_conv <= 1'b0;
    end else begin
      soft_rst <= 1'b0;
      start_init <= 1'b0;
      start_conv <= 1'b0;
      if (byte_stb) begin
        case (wr_idx)
          2'h0: begin
            cmd <= shreg; // a status command needs nothing more: reads start at status
            soft_rst <= (shreg == hts_pkg::CMD_SOFT_RESET);
          end
          2'h1: begin
            param0 <= shreg;
          end
          2'h2: begin
            start_init <= cmd == hts_pkg::CMD_INIT && param0 == hts_pkg::INIT_PARAM0
              && shreg == hts_pkg::INIT_PARAM1;
            start_conv <= cmd == hts_pkg::CMD_MEAS && param0 == hts_pkg::MEAS_PARAM0
              && shreg == hts_pkg::MEAS_PARAM1;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // settling, initialization and conversion sequencing
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      phase <= PH_SETTLE;
      timer <= 32'h0;
      calibrated <= 1'b0;
      result <= '0;
      conv_start <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      if (soft_rst) begin
        phase <= PH_SETTLE;
        timer <= 32'h0;
        calibrated <= 1'b0;
      end else begin
        case (phase)
          PH_SETTLE: begin
            timer <= timer + 32'h1;
            if (timer >= SETTLE_CYC - 1) begin
              phase <= PH_READY;
            end
          end
          PH_READY: begin
            timer <= 32'h0;
            if (start_conv) begin
              phase <= PH_CONV;
              conv_start <= 1'b1;
            end else if (start_init) begin
              phase <= PH_INIT;
            end
          end
          PH_INIT: begin
            timer <= timer + 32'h1;
            if (timer >= INIT_CYC - 1) begin
              phase <= PH_READY;
              calibrated <= 1'b1;
            end
          end
          PH_CONV: begin
            timer <= timer + 32'h1;
            if (timer >= CONV_CYC - 1) begin
              phase <= PH_READY;
              result <= sensor_raw;
            end
          end
          default: begin
            phase <= PH_SETTLE;
            timer <= 32'h0;
          end
        endcase
      end
    end
  end

endmodule : hts_cmd_port

/* tb/hts_cmd_port_sva.sv */
/*
  checker for the sensor serial command port, bound to its top module.
  assumes the host keeps each clock phase at least 8 mclk long.
*/
`timescale 1ns/1ns
module hts_cmd_port_chk #(
  parameter int unsigned SETTLE_CYC = 400,
  parameter int unsigned CONV_CYC = 600
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // bus pins
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // sensing core
  input wire logic conv_start,
  input wire hts_pkg::result_t sensor_raw
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  int unsigned settle_cnt;
  int unsigned conv_cnt;
  // cycles since reset release
  always_ff @(posedge mclk) begin
    if (!rst_n)
      settle_cnt <= 0;
    else if (settle_cnt < SETTLE_CYC)
      settle_cnt <= settle_cnt + 1;
  end
  // cycles since the last conversion start
  always_ff @(posedge mclk) begin
    if (!rst_n)
      conv_cnt <= CONV_CYC;
    else if (conv_start)
      conv_cnt <= 1;
    else if (conv_cnt < CONV_CYC)
      conv_cnt <= conv_cnt + 1;
  end
  property p_clock_free;
    !scl_oe && !scl_out;
  endproperty
  a_clock_free: assert property (p_clock_free) else $error("clock pin driven");
  property p_settle_quiet;
    settle_cnt < SETTLE_CYC |-> !sda_oe;
  endproperty
  a_settle_quiet: assert property (p_settle_quiet) else $error("ack while settling");
  property p_pull_low;
    sda_oe |-> !sda_out;
  endproperty
  a_pull_low: assert property (p_pull_low) else $error("data driven high");
  property p_ack_stands;
    $rose(sda_oe) |=> sda_oe [*8];
  endproperty
  a_ack_stands: assert property (p_ack_stands) else $error("low bit too short");
  property p_change_low;
    $changed(sda_oe) |-> !scl_in && !$past(scl_in);
  endproperty
  a_change_low: assert property (p_change_low) else $error("data moved, clock high");
  property p_high_hold;
    $rose(scl_in) |=> $stable(sda_oe) [*6];
  endproperty
  a_high_hold: assert property (p_high_hold) else $error("data unstable, clock high");
  property p_one_pulse;
    conv_start |=> !conv_start;
  endproperty
  a_one_pulse: assert property (p_one_pulse) else $error("start pulse too long");
  property p_conv_gap;
    conv_start |-> conv_cnt >= CONV_CYC;
  endproperty
  a_conv_gap: assert property (p_conv_gap) else $error("start while busy");
  c_conv: cover property (conv_start);
  c_ack: cover property ($rose(sda_oe) && settle_cnt >= SETTLE_CYC);
  c_release: cover property ($fell(sda_oe));
endmodule : hts_cmd_port_chk

bind hts_cmd_port hts_cmd_port_chk #(
  .SETTLE_CYC(SETTLE_CYC),
  .CONV_CYC(CONV_CYC)
) u_chk (
  .mclk(mclk),
  .rst_n(rst_n),
  .scl_in(scl_in),
  .scl_out(scl_out),
  .scl_oe(scl_oe),
  .sda_in(sda_in),
  .sda_out(sda_out),
  .sda_oe(sda_oe),
  .conv_start(conv_start),
  .sensor_raw(sensor_raw)
);

/* tb/hts_host_model.sv */
/*
  host controller model: start, stop and nine-bit transfers.
  assumes both bus lines have pull-ups resolved by the bench.
*/
`timescale 1ns/1ns
module hts_host_model (
  // clock
  input wire logic mclk,
  // resolved data line
  input wire logic sda_w,
  // host pulls
  output logic scl_low,
  output logic sda_low
);
  // bus idle at time zero
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge mclk);
  endtask : hold
  // works from idle and, as repeated start, with the clock low
  task automatic start();
    sda_low = 1'b0;
    hold(10);
    scl_low = 1'b0;
    hold(10);
    sda_low = 1'b1;
    hold(10);
    scl_low = 1'b1;
    hold(10);
  endtask : start
  task automatic stop();
    sda_low = 1'b1;
    hold(10);
    scl_low = 1'b0;
    hold(10);
    sda_low = 1'b0;
    hold(10);
  endtask : stop
  // one byte plus ninth bit; data moves only while the clock is low
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_low = !tx[i];
      hold(10);
      scl_low = 1'b0;
      hold(5);
      rx[i] = sda_w;
      hold(5);
      scl_low = 1'b1;
      hold(3);
    end
  endtask : xfer
endmodule : hts_host_model

/* tb/tb.sv */
/*
  self-checking bench for the sensor serial command port.
  assumes the host model and a pulled-up two-wire bus.
*/
`timescale 1ns/1ns
module tb;
  localparam int unsigned SETTLE = 400;
  localparam int unsigned INIT = 2000;
  localparam int unsigned CONV = 3000;
  typedef struct packed {
    logic [7:0] addr;
    logic ack;
    logic [7:0] stat;
  } row_t;
  logic mclk, rst_n, scl_out, scl_oe, sda_out, sda_oe, conv_start, scl_low, sda_low;
  hts_pkg::result_t sensor_raw;
  int fail_count = 0;
  int checks_done = 0;
  logic [7:0] conv_seen = 8'h00;
  logic [7:0] q [0:7];
  logic [8:0] rx;
  logic [63:0] e;
  row_t rows [0:5] = '{'{8'h70, 1'b1, 8'h00}, '{8'h71, 1'b1, 8'h00}, '{8'h72, 1'b0, 8'h00},
    '{8'h73, 1'b0, 8'h00}, '{8'hF0, 1'b0, 8'h00}, '{8'h10, 1'b0, 8'h00}};
  // wired-and lines with pull-ups
  wire scl_w = !(scl_low || scl_oe);
  wire sda_w = !(sda_low || sda_oe);
  hts_cmd_port #(.SETTLE_CYC(SETTLE), .INIT_CYC(INIT), .CONV_CYC(CONV)) dut (
    .mclk(mclk), .rst_n(rst_n), .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .conv_start(conv_start),
    .sensor_raw(sensor_raw));
  hts_host_model h (.mclk(mclk), .sda_w(sda_w), .scl_low(scl_low), .sda_low(sda_low));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask : chk
  // address, one byte more if it is an acked read, then stop
  task automatic probe(input logic [7:0] a, input logic ack);
    h.start();
    h.xfer({a, 1'b1}, rx);
    chk("address ack", {7'h00, ack}, {7'h00, !rx[0]});
    // an acked read drives data at once: take one byte and nack it before the stop
    if (a[0] && !rx[0]) begin
      h.xfer({8'hFF, 1'b1}, rx);
      q[0] = rx[8:1];
    end
    h.stop();
  endtask : probe
  task automatic cmd(input logic [23:0] b, input int n);
    probe({hts_pkg::TARGET_ADDR, 1'b0}, 1'b1);
    h.start();
    h.xfer({hts_pkg::TARGET_ADDR, 2'b01}, rx);
    for (int i = 0; i < n; i++) begin
      h.xfer({b[23 - 8 * i -: 8], 1'b1}, rx);
      chk("byte ack", 8'h00, {7'h00, rx[0]});
    end
    h.stop();
  endtask : cmd
  // read n bytes, acking all but the last
  task automatic rd(input int n);
    h.start();
    h.xfer({hts_pkg::TARGET_ADDR, 2'b11}, rx);
    for (int i = 0; i < n; i++) begin
      h.xfer({8'hFF, i == n - 1}, rx);
      q[i] = rx[8:1];
    end
    h.stop();
  endtask : rd
  task automatic stat(input logic [7:0] exp);
    cmd({hts_pkg::CMD_STATUS, 16'h0000}, 1);
    rd(1);
    chk("status", exp, q[0]);
  endtask : stat
  function automatic logic [7:0] crc8(input logic [47:0] d);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 47; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? hts_pkg::CRC_POLY : 8'h00);
    return c;
  endfunction : crc8
  task automatic report_and_stop();
    if (fail_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  // clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // conversion start counter
  always @(posedge mclk) begin
    if (conv_start === 1'b1)
      conv_seen <= conv_seen + 8'h01;
  end
  // watchdog
  initial begin
    repeat (60000) @(posedge mclk);
    fail_count++;
    report_and_stop();
  end
  // main sequence
  initial begin
    rst_n = 1'b0;
    sensor_raw = 40'h12345_ABCDE;
    repeat (2) @(negedge mclk);
    chk("reset outputs", 8'h00, {5'h00, sda_oe, scl_oe, conv_start});
    rst_n = 1'b1;
    probe(8'h70, 1'b0);
    repeat (SETTLE) @(negedge mclk);
    foreach (rows[i]) begin
      probe(rows[i].addr, rows[i].ack);
      if (rows[i].ack && rows[i].addr[0]) begin
        rd(1);
        chk("status", rows[i].stat, q[0]);
      end
    end
    cmd({hts_pkg::CMD_INIT, hts_pkg::INIT_PARAM0, hts_pkg::INIT_PARAM1}, 3);
    stat(8'h00);
    repeat (INIT) @(negedge mclk);
    stat(8'h08);
    cmd({hts_pkg::CMD_MEAS, 8'h34, 8'h00}, 3);
    cmd({hts_pkg::CMD_MEAS, hts_pkg::MEAS_PARAM0, hts_pkg::MEAS_PARAM1}, 3);
    chk("conversion starts", 8'h01, conv_seen);
    stat(8'h88);
    cmd({hts_pkg::CMD_MEAS, hts_pkg::MEAS_PARAM0, hts_pkg::MEAS_PARAM1}, 3);
    chk("busy trigger", 8'h01, conv_seen);
    repeat (CONV) @(negedge mclk);
    e = {8'h08, sensor_raw, crc8({8'h08, sensor_raw}), 8'hFF};
    rd(8);
    for (int i = 0; i < 8; i++)
      chk("result byte", e[63 - 8 * i -: 8], q[i]);
    chk("humidity msb", sensor_raw.raw_humidity_value[19:12], q[1]);
    chk("temperature lsb", sensor_raw.raw_temperature_value[7:0], q[5]);
    cmd({hts_pkg::CMD_SOFT_RESET, 16'h0000}, 1);
    probe(8'h71, 1'b0);
    repeat (SETTLE) @(negedge mclk);
    stat(8'h00);
    report_and_stop();
  end
endmodule : tb
